//--- src/hotrunner_pkg.sv
// Constants, register map and carrier types for the hot-runner sequencer.
// Assumes a single 200 MHz clock and an AHB-Lite register bus.
//
// Overview of operation
// - Hot-runner output pulses on a fixed 0.1 s cycle
// - Hot-runner mode alone unlocks start-up and boost
// - Start-up enabled by setting or binary input
// - Start-up runs only with pd-pi controller type
// - Reset or leaving off: start if 2 C low
// - Fall 40 C below restarts the start-up
// - Start-up ends above start setpoint minus 2 C
// - Start-up clamps output to start-up factor
// - Dwell holds actuation setpoint, then valid setpoint
// - Unreachable exit keeps start-up running forever
// - Function bit 3 starts boosting from any source
// - Boost ends on bit clear or time limit
// - Boost adds to setpoint 1/2 only
// - Boost display shows plain setpoint with mark
// - Closed contact adds feed-forward amount to output
// - No feed-forward in self-tuning or step-action
// - Adaptive correction forwards mean actual value only
// - Setpoint 1/2 and actuation setpoint entries outside bounds are rejected
// - Limit monitoring uses switching hysteresis, default 4
`default_nettype none

package hotrunner_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS     = 5;
  localparam int ACT_CYCLE_MS      = 100;
  localparam int ACT_CYCLE_CYCLES  = ACT_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PWM_SLOTS         = 100;
  localparam int TICKS_PER_SEC     = 10;
  localparam int DWELL_MAX_S       = 300;
  localparam int BOOST_MAX_S       = 600;

  // ==========================================================
  // Thresholds and reset values
  localparam logic signed [16:0] STARTUP_BAND_C = 17'sh00002;
  localparam logic signed [16:0] RESTART_BAND_C = 17'sh00028;
  localparam logic signed [15:0] Y_LIMIT        = 16'sh0064;
  localparam logic [15:0]        HYST_RESET     = 16'h0004;
  localparam logic [7:0]         STARTUP_Y_RESET = 8'h0A;
  localparam logic [7:0]         CYCLE_RESET    = 8'h0A;
  localparam logic [15:0]        SP_HI_RESET    = 16'h7FFF;
  localparam logic [15:0]        SP_LO_RESET    = 16'h8000;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_SP1       = 8'h04;
  localparam logic [7:0] OFF_SP2       = 8'h08;
  localparam logic [7:0] OFF_SU_SP     = 8'h0C;
  localparam logic [7:0] OFF_ACT_SP    = 8'h10;
  localparam logic [7:0] OFF_SU_Y      = 8'h14;
  localparam logic [7:0] OFF_DWELL     = 8'h18;
  localparam logic [7:0] OFF_BOOST_INC = 8'h1C;
  localparam logic [7:0] OFF_BOOST_MAX = 8'h20;
  localparam logic [7:0] OFF_FF        = 8'h24;
  localparam logic [7:0] OFF_SP_LO     = 8'h28;
  localparam logic [7:0] OFF_SP_HI     = 8'h2C;
  localparam logic [7:0] OFF_HYST      = 8'h30;
  localparam logic [7:0] OFF_LIMIT     = 8'h34;
  localparam logic [7:0] OFF_CYCLE     = 8'h38;
  localparam logic [7:0] OFF_STATUS    = 8'h3C;
  localparam logic [7:0] OFF_MEAN      = 8'h40;

  // ==========================================================
  // Types
  typedef logic signed [15:0] temp_t;
  typedef logic signed [7:0]  pct_t;
  typedef enum logic [1:0] {BI_NONE, BI_STARTUP, BI_BOOST, BI_FEEDFWD} bi_func_t;
  typedef enum logic [1:0] {ST_IDLE, ST_STARTUP, ST_DWELL, ST_NORMAL} phase_t;

  // Control word, bit 0 upward: hot .. sp2_sel, then binary_input_function
  typedef struct packed {
    bi_func_t binary_input_function;
    logic     sp2_sel;
    logic     off;
    logic     adaptive;
    logic     step_action;
    logic     selftune;
    logic     boost;
    logic     pd_pi_controller_type;
    logic     startup_enable;
    logic     hot;
  } cfg_t;

  typedef struct packed {
    logic  heater_pulse;
    pct_t  manip_factor;
    temp_t regulation_setpoint;
    temp_t mean_actual;
    temp_t display_value;
    logic  display_boost_mark;
    logic  limit_alarm;
  } ctl_out_t;

  typedef struct packed {
    cfg_t        cfg;
    temp_t       sp1, sp2, su_sp, actuation_setpoint, boost_increase;
    temp_t       sp_lo, sp_hi, limit, peak, valley;
    logic [15:0] switching_hysteresis;
    pct_t        startup_output_factor, feedforward_amount;
    logic [8:0]  dwell_duration;
    logic [9:0]  boost_max_duration, dwell_sec, boost_sec;
    logic [7:0]  cycle, pwm_sub;
    phase_t      phase;
    logic [31:0] cyc_cnt;
    logic [6:0]  slot_cnt, pwm_slot;
    logic [3:0]  dec_cnt;
    logic        sync1, sync2, contact;
    logic        wr_pend, reject, ready;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    ctl_out_t    out;
  } regs_t;

endpackage

`default_nettype wire

//--- src/hot_runner_startup_boost.sv
// Hot-runner start-up, dwell, boost and feed-forward sequencer.
// Assumes an AHB-Lite master on hclk; actual value and PID factor come
// from logic on the same clock; the binary contact is an asynchronous pin.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`default_nettype none

module hot_runner_startup_boost #(
  parameter int unsigned TICK_CYCLES = hotrunner_pkg::ACT_CYCLE_CYCLES
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire hotrunner_pkg::temp_t     actual_value,
  input  wire hotrunner_pkg::pct_t      pid_factor,
  input  wire logic                     contact_pin,
  output hotrunner_pkg::ctl_out_t       ctl
);

  localparam int unsigned SLOT_RAW    = TICK_CYCLES / hotrunner_pkg::PWM_SLOTS;
  localparam int unsigned SLOT_CYCLES = (SLOT_RAW > 0) ? SLOT_RAW : 1;

  hotrunner_pkg::regs_t q_reg, q_next;

  // ==========================================================
  // Helpers
  function automatic logic signed [16:0] diff(input logic signed [15:0] a, input logic signed [15:0] b);
    diff = 17'(a) - 17'(b);
  endfunction

  function automatic logic in_range(input logic signed [15:0] v, input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  logic                 slot_pulse, tick, sec, pwm_step, en, boost_act, ff_act, addr_ph;
  logic [7:0]           mult;
  logic signed [15:0]   wd, mean, pv, base_sp;
  logic signed [16:0]   dv;
  logic signed [9:0]    y;

  // Time base, enables and derived values
  always_comb begin
    slot_pulse = (q_reg.cyc_cnt == 32'(SLOT_CYCLES - 1));
    tick       = slot_pulse && (q_reg.slot_cnt == 7'(hotrunner_pkg::PWM_SLOTS - 1));
    sec        = tick && (q_reg.dec_cnt == 4'(hotrunner_pkg::TICKS_PER_SEC - 1));
    mult       = q_reg.cfg.hot ? 8'h01 : ((q_reg.cycle == 8'h00) ? 8'h01 : q_reg.cycle);
    pwm_step   = slot_pulse && (q_reg.pwm_sub >= mult - 8'h01);
    mean       = 16'((17'(q_reg.peak) + 17'(q_reg.valley)) >>> 1);
    pv         = q_reg.cfg.adaptive ? mean : actual_value;
    dv         = diff(pv, q_reg.su_sp);
    en         = q_reg.cfg.hot && q_reg.cfg.pd_pi_controller_type && !q_reg.cfg.off
                 && (q_reg.cfg.startup_enable
                     || (q_reg.cfg.binary_input_function == hotrunner_pkg::BI_STARTUP && q_reg.contact));
    boost_act  = q_reg.cfg.boost && q_reg.cfg.hot;
    ff_act     = q_reg.cfg.binary_input_function == hotrunner_pkg::BI_FEEDFWD && q_reg.contact
                 && !q_reg.cfg.selftune && !q_reg.cfg.step_action;
    base_sp    = q_reg.cfg.sp2_sel ? q_reg.sp2 : q_reg.sp1;
    wd         = hwdata[15:0];
    addr_ph    = hsel && htrans[1] && hready;
  end

  // Next state: bus, timers, sequencer and outputs
  always_comb begin
    q_next         = q_reg;
    q_next.sync1   = contact_pin;
    q_next.sync2   = q_reg.sync1;
    q_next.contact = q_reg.sync2;

    // Time base: slots of one hundredth of the 0.1 s cycle
    q_next.cyc_cnt = slot_pulse ? 32'h00000000 : q_reg.cyc_cnt + 32'h00000001;
    if (slot_pulse) begin
      q_next.slot_cnt = tick ? 7'h00 : q_reg.slot_cnt + 7'h01;
      q_next.pwm_sub  = pwm_step ? 8'h00 : q_reg.pwm_sub + 8'h01;
    end
    if (pwm_step) begin
      q_next.pwm_slot = (q_reg.pwm_slot == 7'(hotrunner_pkg::PWM_SLOTS - 1)) ? 7'h00 : q_reg.pwm_slot + 7'h01;
    end
    if (tick) begin
      q_next.dec_cnt = sec ? 4'h0 : q_reg.dec_cnt + 4'h1;
    end

    // Envelope tracker: mean of decaying peak and valley
    if (tick) begin
      if (diff(actual_value, q_reg.peak) > 0) begin
        q_next.peak = actual_value;
      end else begin
        q_next.peak = 16'(17'(q_reg.peak) + (diff(actual_value, q_reg.peak) >>> 3));
      end
      if (diff(actual_value, q_reg.valley) < 0) begin
        q_next.valley = actual_value;
      end else begin
        q_next.valley = 16'(17'(q_reg.valley) + (diff(actual_value, q_reg.valley) >>> 3));
      end
    end

    // Boost timeout clears first so that any set below wins
    if (boost_act && sec) begin
      if (q_reg.boost_sec + 10'h001 >= q_reg.boost_max_duration) begin
        q_next.cfg.boost = 1'b0;
      end else begin
        q_next.boost_sec = q_reg.boost_sec + 10'h001;
      end
    end

    // Register write data phase
    q_next.wr_pend = addr_ph && hwrite;
    q_next.wr_addr = haddr[7:0];
    if (q_reg.wr_pend) begin
      q_next.reject = 1'b0;
      unique case (q_reg.wr_addr)
        hotrunner_pkg::OFF_CTRL:      q_next.cfg = hotrunner_pkg::cfg_t'(hwdata[10:0]);
        hotrunner_pkg::OFF_SP1,
        hotrunner_pkg::OFF_SP2,
        hotrunner_pkg::OFF_ACT_SP: begin
          if (!in_range(wd, q_reg.sp_lo, q_reg.sp_hi)) begin
            q_next.reject = 1'b1;
          end else if (q_reg.wr_addr == hotrunner_pkg::OFF_SP1) begin
            q_next.sp1 = wd;
          end else if (q_reg.wr_addr == hotrunner_pkg::OFF_SP2) begin
            q_next.sp2 = wd;
          end else begin
            q_next.actuation_setpoint = wd;
          end
        end
        hotrunner_pkg::OFF_SU_SP:     q_next.su_sp = wd;
        hotrunner_pkg::OFF_SU_Y,
        hotrunner_pkg::OFF_FF: begin
          if (!in_range(wd, -hotrunner_pkg::Y_LIMIT, hotrunner_pkg::Y_LIMIT)) begin
            q_next.reject = 1'b1;
          end else if (q_reg.wr_addr == hotrunner_pkg::OFF_SU_Y) begin
            q_next.startup_output_factor = wd[7:0];
          end else begin
            q_next.feedforward_amount = wd[7:0];
          end
        end
        hotrunner_pkg::OFF_DWELL: begin
          // Unsigned compare so that negative entries are refused too
          if ($unsigned(wd) > 16'(hotrunner_pkg::DWELL_MAX_S)) q_next.reject = 1'b1;
          else q_next.dwell_duration = wd[8:0];
        end
        hotrunner_pkg::OFF_BOOST_MAX: begin
          if ($unsigned(wd) > 16'(hotrunner_pkg::BOOST_MAX_S)) q_next.reject = 1'b1;
          else q_next.boost_max_duration = wd[9:0];
        end
        hotrunner_pkg::OFF_BOOST_INC: q_next.boost_increase = wd;
        hotrunner_pkg::OFF_SP_LO:     q_next.sp_lo = wd;
        hotrunner_pkg::OFF_SP_HI:     q_next.sp_hi = wd;
        hotrunner_pkg::OFF_HYST:      q_next.switching_hysteresis = wd;
        hotrunner_pkg::OFF_LIMIT:     q_next.limit = wd;
        hotrunner_pkg::OFF_CYCLE:     q_next.cycle = wd[7:0];
        default:                      q_next.reject = q_reg.reject;
      endcase
    end

    // Binary input assigned to boosting follows the contact edges
    if (q_reg.cfg.binary_input_function == hotrunner_pkg::BI_BOOST && q_reg.sync2 != q_reg.contact) begin
      q_next.cfg.boost = q_reg.sync2;
    end
    if (q_next.cfg.boost && !q_reg.cfg.boost) begin
      q_next.boost_sec = 10'h000;
    end

    // Start-up sequencer
    if (!en) begin
      q_next.phase = hotrunner_pkg::ST_IDLE;
    end else begin
      unique case (q_reg.phase)
        hotrunner_pkg::ST_IDLE: begin
          q_next.phase = (dv < -hotrunner_pkg::STARTUP_BAND_C) ? hotrunner_pkg::ST_STARTUP
                                                               : hotrunner_pkg::ST_NORMAL;
        end
        hotrunner_pkg::ST_STARTUP: begin
          if (dv > -hotrunner_pkg::STARTUP_BAND_C) begin
            q_next.phase     = hotrunner_pkg::ST_DWELL;
            q_next.dwell_sec = 10'h000;
          end
        end
        hotrunner_pkg::ST_DWELL: begin
          if (dv < -hotrunner_pkg::RESTART_BAND_C) begin
            q_next.phase = hotrunner_pkg::ST_STARTUP;
          end else if (q_reg.dwell_sec >= 10'(q_reg.dwell_duration)) begin
            q_next.phase = hotrunner_pkg::ST_NORMAL;
          end else if (sec) begin
            q_next.dwell_sec = q_reg.dwell_sec + 10'h001;
          end
        end
        hotrunner_pkg::ST_NORMAL: begin
          if (dv < -hotrunner_pkg::RESTART_BAND_C) q_next.phase = hotrunner_pkg::ST_STARTUP;
        end
      endcase
    end

    // Manipulating factor with feed-forward and start-up clamp
    y = 10'(pid_factor) + (ff_act ? 10'(q_reg.feedforward_amount) : 10'sh000);
    if (q_reg.phase == hotrunner_pkg::ST_STARTUP && y > 10'(q_reg.startup_output_factor)) begin
      y = 10'(q_reg.startup_output_factor);
    end
    if (y > 10'(hotrunner_pkg::Y_LIMIT)) y = 10'(hotrunner_pkg::Y_LIMIT);
    if (y < -10'(hotrunner_pkg::Y_LIMIT)) y = -10'(hotrunner_pkg::Y_LIMIT);
    q_next.out.manip_factor = y[7:0];
    q_next.out.heater_pulse = $signed({3'b000, q_reg.pwm_slot}) < y;

    // Setpoint routing and display
    unique case (q_reg.phase)
      hotrunner_pkg::ST_STARTUP: q_next.out.regulation_setpoint = q_reg.su_sp;
      hotrunner_pkg::ST_DWELL:   q_next.out.regulation_setpoint = q_reg.actuation_setpoint;
      default: q_next.out.regulation_setpoint = base_sp + (boost_act ? q_reg.boost_increase : 16'h0000);
    endcase
    q_next.out.display_value      = base_sp;
    q_next.out.display_boost_mark = boost_act;
    q_next.out.mean_actual        = pv;

    // Limit monitoring with hysteresis
    if (diff(pv, q_reg.limit) > 0) begin
      q_next.out.limit_alarm = 1'b1;
    end else if (diff(pv, q_reg.limit) < -17'($signed({1'b0, q_reg.switching_hysteresis}))) begin
      q_next.out.limit_alarm = 1'b0;
    end

    // Read data taken in the address phase from the updated values
    q_next.rdata = 32'h00000000;
    if (addr_ph && !hwrite) begin
      unique case (haddr[7:0])
        hotrunner_pkg::OFF_CTRL:      q_next.rdata = 32'(q_next.cfg);
        hotrunner_pkg::OFF_SP1:       q_next.rdata = 32'(q_next.sp1);
        hotrunner_pkg::OFF_SP2:       q_next.rdata = 32'(q_next.sp2);
        hotrunner_pkg::OFF_SU_SP:     q_next.rdata = 32'(q_next.su_sp);
        hotrunner_pkg::OFF_ACT_SP:    q_next.rdata = 32'(q_next.actuation_setpoint);
        hotrunner_pkg::OFF_SU_Y:      q_next.rdata = 32'(q_next.startup_output_factor);
        hotrunner_pkg::OFF_DWELL:     q_next.rdata = 32'(q_next.dwell_duration);
        hotrunner_pkg::OFF_BOOST_INC: q_next.rdata = 32'(q_next.boost_increase);
        hotrunner_pkg::OFF_BOOST_MAX: q_next.rdata = 32'(q_next.boost_max_duration);
        hotrunner_pkg::OFF_FF:        q_next.rdata = 32'(q_next.feedforward_amount);
        hotrunner_pkg::OFF_SP_LO:     q_next.rdata = 32'(q_next.sp_lo);
        hotrunner_pkg::OFF_SP_HI:     q_next.rdata = 32'(q_next.sp_hi);
        hotrunner_pkg::OFF_HYST:      q_next.rdata = 32'(q_next.switching_hysteresis);
        hotrunner_pkg::OFF_LIMIT:     q_next.rdata = 32'(q_next.limit);
        hotrunner_pkg::OFF_CYCLE:     q_next.rdata = 32'(q_next.cycle);
        hotrunner_pkg::OFF_STATUS:    q_next.rdata = {26'h0, q_reg.phase, q_reg.out.limit_alarm,
                                                      q_next.reject, boost_act, q_reg.contact};
        hotrunner_pkg::OFF_MEAN:      q_next.rdata = 32'(pv);
        default:                      q_next.rdata = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_reg                       <= '0;
      q_reg.ready                 <= 1'b1;
      q_reg.sp_hi                 <= hotrunner_pkg::SP_HI_RESET;
      q_reg.sp_lo                 <= hotrunner_pkg::SP_LO_RESET;
      q_reg.switching_hysteresis  <= hotrunner_pkg::HYST_RESET;
      q_reg.startup_output_factor <= hotrunner_pkg::STARTUP_Y_RESET;
      q_reg.cycle                 <= hotrunner_pkg::CYCLE_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  assign hreadyout = q_reg.ready;
  assign hresp     = 1'b0;
  assign hrdata    = q_reg.rdata;
  assign ctl       = q_reg.out;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_cold;
    en && q_reg.phase == hotrunner_pkg::ST_IDLE && dv < -hotrunner_pkg::STARTUP_BAND_C;
  endsequence
  sequence seq_warm;
    en && q_reg.phase == hotrunner_pkg::ST_STARTUP && dv > -hotrunner_pkg::STARTUP_BAND_C;
  endsequence

  a_startup_entry: assert property (seq_cold |=> q_reg.phase == hotrunner_pkg::ST_STARTUP)
    else $error("start-up not entered from idle");
  a_dwell_entry: assert property (seq_warm |=> q_reg.phase == hotrunner_pkg::ST_DWELL ##1
                                  q_reg.out.regulation_setpoint == $past(q_reg.actuation_setpoint))
    else $error("dwell not entered");
  a_restart_low: assert property (en && q_reg.phase inside {hotrunner_pkg::ST_DWELL, hotrunner_pkg::ST_NORMAL}
                                  && dv < -hotrunner_pkg::RESTART_BAND_C |=> q_reg.phase == hotrunner_pkg::ST_STARTUP)
    else $error("start-up not restarted");
  a_pd_pi_controller_type_only: assert property (!q_reg.cfg.pd_pi_controller_type |=> q_reg.phase == hotrunner_pkg::ST_IDLE)
    else $error("start-up active without pd-pi");
  a_startup_clamp: assert property (q_reg.phase == hotrunner_pkg::ST_STARTUP
                                    |=> ctl.manip_factor <= $past(q_reg.startup_output_factor))
    else $error("start-up factor exceeded");
  a_hot_pwm_step: assert property (q_reg.cfg.hot && slot_pulse && q_reg.pwm_slot < 7'h63
                                   |=> q_reg.pwm_slot == $past(q_reg.pwm_slot) + 7'h01)
    else $error("hot-runner cycle not fixed");
  a_ff_blocked: assert property (q_reg.cfg.selftune && q_reg.phase != hotrunner_pkg::ST_STARTUP
                                 |=> ctl.manip_factor == $past(pid_factor))
    else $error("feed-forward during self-tuning");
  a_sp_reject: assert property (q_reg.wr_pend && q_reg.wr_addr == hotrunner_pkg::OFF_SP1
                                && !in_range(wd, q_reg.sp_lo, q_reg.sp_hi) |=> $stable(q_reg.sp1) && q_reg.reject)
    else $error("out-of-range setpoint accepted");
  a_boost_mark: assert property (boost_act && q_reg.phase == hotrunner_pkg::ST_IDLE && !q_reg.cfg.sp2_sel
                                 |=> ctl.display_boost_mark && ctl.display_value == $past(q_reg.sp1)
                                     && ctl.regulation_setpoint == $past(q_reg.sp1) + $past(q_reg.boost_increase))
    else $error("boost display or setpoint wrong");

  // Start-up regulates to its own setpoint, untouched by boosting
  a_startup_sp: assert property (q_reg.phase == hotrunner_pkg::ST_STARTUP
                                 |=> ctl.regulation_setpoint == $past(q_reg.su_sp))
    else $error("start-up setpoint altered");

  // Time limit drops the function bit unless a write or contact overrides
  a_boost_timeout: assert property (boost_act && sec && !q_reg.wr_pend
                                    && q_reg.boost_sec + 10'h001 >= q_reg.boost_max_duration
                                    && q_reg.cfg.binary_input_function != hotrunner_pkg::BI_BOOST
                                    |=> !q_reg.cfg.boost)
    else $error("boost time limit ignored");

  // Value above the limit raises the alarm on the next cycle
  a_limit_set: assert property (diff(pv, q_reg.limit) > 0 |=> ctl.limit_alarm)
    else $error("limit alarm not raised");

endmodule

`default_nettype wire

//--- tb/plant_model.sv
// Sensor and heater stand-in for the hot-runner sequencer bench.
// Assumes hclk from the bench; temperature is commanded by the bench.
`default_nettype none

module plant_model (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 heater_pulse,
  input  wire hotrunner_pkg::temp_t temp_cmd,
  output hotrunner_pkg::temp_t      actual_value,
  output logic [15:0]               pulse_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  // ==========================================================
  // Sensor follows command; count heater pulse starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      actual_value <= '0;
      pulse_count  <= '0;
      last         <= 1'b0;
    end else begin
      actual_value <= temp_cmd;
      last         <= heater_pulse;
      if (heater_pulse && !last) pulse_count <= pulse_count + 16'h0001;
    end
  end
endmodule

`default_nettype wire

//--- tb/test_hot_runner_startup_boost.sv
// Self-checking bench for the hot-runner sequencer over AHB-Lite.
// Assumes TICK_CYCLES of 1000 so one second is 10000 cycles.
`default_nettype none

module test_hot_runner_startup_boost;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, contact_pin = 0;
  logic [31:0]               haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]                htrans = 0;
  logic                      hreadyout, hresp;
  hotrunner_pkg::temp_t      actual_value, temp_cmd = 16'sh0000;
  hotrunner_pkg::pct_t       pid_factor = 8'sh00;
  hotrunner_pkg::ctl_out_t   ctl;
  logic [15:0]               pulse_count, c0;
  int                        fail_count = 0, samples_checked = 0, cycles = 0;

  hot_runner_startup_boost #(.TICK_CYCLES(1000)) hot_runner_startup_boost_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .actual_value(actual_value),
    .pid_factor(pid_factor), .contact_pin(contact_pin), .ctl(ctl));
  plant_model plant_model_i (.hclk(hclk), .hresetn(hresetn), .heater_pulse(ctl.heater_pulse),
    .temp_cmd(temp_cmd), .actual_value(actual_value), .pulse_count(pulse_count));

  // ==========================================================
  // Clock and hang guard
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      end_sim();
    end
  end

  // ==========================================================
  // Bus, compare and closing tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdw(input logic [7:0] a);
    bus(1'b0, a, 32'h00000000);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_phase(input logic [1:0] p);
    rdw(hotrunner_pkg::OFF_STATUS);
    for (int i = 0; i < 9000 && rd[5:4] !== p; i++) rdw(hotrunner_pkg::OFF_STATUS);
    chk("phase", {30'h0, p}, {30'h0, rd[5:4]});
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdw(hotrunner_pkg::OFF_HYST); chk("hyst", 32'h00000004, rd);
    wr(hotrunner_pkg::OFF_SP_LO, 32'h00000000);
    wr(hotrunner_pkg::OFF_SP_HI, 32'h000000C8);
    wr(hotrunner_pkg::OFF_SP1, 32'h00000096);
    wr(hotrunner_pkg::OFF_SP1, 32'h0000012C);
    rdw(hotrunner_pkg::OFF_SP1); chk("sp1", 32'h00000096, rd);
    rdw(hotrunner_pkg::OFF_STATUS); chk("reject", 32'h00000001, {31'h0, rd[2]});
    $display("test limits done");
    temp_cmd <= 16'sh0032;
    pid_factor <= 8'sh50;
    wr(hotrunner_pkg::OFF_SU_SP, 32'h00000064);
    wr(hotrunner_pkg::OFF_ACT_SP, 32'h00000050);
    wr(hotrunner_pkg::OFF_SU_Y, 32'h00000014);
    wr(hotrunner_pkg::OFF_DWELL, 32'h00000001);
    wr(hotrunner_pkg::OFF_CYCLE, 32'h00000014);
    // Missing hot mode, then missing pd-pi type: never start up
    for (int i = 0; i < 2; i++) begin
      wr(hotrunner_pkg::OFF_CTRL, i ? 32'h00000003 : 32'h00000006);
      repeat (50) @(posedge hclk);
      rdw(hotrunner_pkg::OFF_STATUS); chk("no_startup", 32'h0, {31'h0, rd[5:4] === 2'h1});
      wr(hotrunner_pkg::OFF_CTRL, 32'h00000000);
    end
    wr(hotrunner_pkg::OFF_CTRL, 32'h00000007);
    wait_phase(2'h1);
    chk("clamp", 32'h14, {24'h0, ctl.manip_factor});
    temp_cmd <= 16'sh0063;
    wait_phase(2'h2);
    chk("dwell_sp", 32'h50, {16'h0, ctl.regulation_setpoint});
    wait_phase(2'h3);
    chk("valid_sp", 32'h96, {16'h0, ctl.regulation_setpoint});
    c0 = pulse_count;
    repeat (5000) @(posedge hclk);
    chk("pulses", 32'h5, {16'h0, pulse_count - c0});
    temp_cmd <= 16'sh003B;
    wait_phase(2'h1);
    $display("test startup done");
    wr(hotrunner_pkg::OFF_CTRL, 32'h00000000);
    wr(hotrunner_pkg::OFF_BOOST_INC, 32'h0000000A);
    wr(hotrunner_pkg::OFF_BOOST_MAX, 32'h00000001);
    wr(hotrunner_pkg::OFF_CTRL, 32'h0000000D);
    repeat (5) @(posedge hclk);
    chk("mark", 32'h1, {31'h0, ctl.display_boost_mark});
    chk("display", 32'h96, {16'h0, ctl.display_value});
    chk("boost_sp", 32'hA0, {16'h0, ctl.regulation_setpoint});
    for (int i = 0; i < 15000 && ctl.display_boost_mark === 1'b1; i++) @(posedge hclk);
    chk("boost_end", 32'h0, {31'h0, ctl.display_boost_mark});
    rdw(hotrunner_pkg::OFF_CTRL); chk("bit3", 32'h0, {31'h0, rd[3]});
    $display("test boost done");
    wr(hotrunner_pkg::OFF_FF, 32'h0000001E);
    pid_factor <= 8'sh28;
    // Plain, self-tuning and step-action configurations
    for (int i = 0; i < 3; i++) begin
      wr(hotrunner_pkg::OFF_CTRL, 32'h00000601 | (32'(i) * 32'h00000010));
      contact_pin <= 1'b1;
      repeat (10) @(posedge hclk);
      chk("ff_on", i ? 32'h28 : 32'h46, {24'h0, ctl.manip_factor});
      contact_pin <= 1'b0;
      repeat (10) @(posedge hclk);
      chk("ff_off", 32'h28, {24'h0, ctl.manip_factor});
    end
    $display("test feedforward done");
    // Limit alarm with hysteresis, plain actual value forwarding
    wr(hotrunner_pkg::OFF_LIMIT, 32'h00000064);
    repeat (5) @(posedge hclk);
    chk("mean", 32'h3B, {16'h0, ctl.mean_actual});
    chk("alarm_off", 32'h0, {31'h0, ctl.limit_alarm});
    temp_cmd <= 16'sh0065;
    repeat (5) @(posedge hclk);
    chk("alarm_on", 32'h1, {31'h0, ctl.limit_alarm});
    temp_cmd <= 16'sh0061;
    repeat (5) @(posedge hclk);
    chk("alarm_hold", 32'h1, {31'h0, ctl.limit_alarm});
    // Boost from the binary input on setpoint 2
    wr(hotrunner_pkg::OFF_SP2, 32'h00000064);
    wr(hotrunner_pkg::OFF_BOOST_MAX, 32'h00000258);
    wr(hotrunner_pkg::OFF_BOOST_MAX, 32'h00000259);
    rdw(hotrunner_pkg::OFF_BOOST_MAX); chk("boost_max", 32'h258, rd);
    wr(hotrunner_pkg::OFF_CTRL, 32'h00000505);
    contact_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("bi_boost", 32'h6E, {16'h0, ctl.regulation_setpoint});
    chk("sp2_disp", 32'h64, {16'h0, ctl.display_value});
    contact_pin <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("bi_boost_off", 32'h0, {31'h0, ctl.display_boost_mark});
    $display("test inputs done");
    end_sim();
  end
endmodule

`default_nettype wire
